// *** pef_pkg.sv ***
// Shared constants and types for the phase-encoded tape formatter.
// Assumes a single core clock; all tape-side signals arrive as pins.
`default_nettype none

package pef_pkg;

  localparam int CH_N = 9;                  // Channels 0..7 in bits 7:0, parity in bit 8

  // Write sequencer counts, in doubled write clock edges
  localparam logic [6:0] FLUX_COUNT = 7'h50;   // 80 flux reversals, 40 zero characters
  localparam logic [6:0] ONES_TICKS = 7'h02;   // One bit period of held flux clock
  localparam logic [6:0] CNT_LAST   = 7'h01;

  // Flux clock groups per channel
  localparam logic [8:0] MASK_GROUP_B = 9'h01A; // Channels 1, 3, 4
  localparam logic [8:0] MASK_PARITY  = 9'h100; // Parity channel only

  // Read discriminator and divide-by-22 feedback
  localparam logic [3:0] WIN_FULL    = 4'hF;    // Bit-window carry count
  localparam logic [3:0] WIN_STEP    = 4'h1;
  localparam logic [3:0] DIV_PRELOAD = 4'hA;
  localparam logic [3:0] DIV_TOP     = 4'hF;
  localparam logic [3:0] GAP_MIN     = 4'h2;    // Inactive channels that mean a gap

  // Register map (byte addresses) and field positions
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam int          CTRL_FWD_BIT  = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam int          ST_DROP_LSB   = 0;
  localparam int          ST_GAP_BIT    = 9;
  localparam int          ST_DAV_LSB    = 10;
  localparam int          ST_STATE_LSB  = 19;

  // Command encoding on the two control lines {high, low}
  typedef enum logic [1:0] {
    CMD_RESET    = 2'h0,
    CMD_IDBURST  = 2'h1,
    CMD_FILEMARK = 2'h2,
    CMD_WRITE    = 2'h3
  } pef_cmd_t;

  typedef struct packed {
    logic high;
    logic low;
  } pef_cmdlines_t;

  // Every input that crosses into the core clock domain
  typedef struct packed {
    logic          dwClk;
    pef_cmdlines_t cmd;
    logic          finalN;
    logic          rrClk;
    logic [8:0]    dropN;
    logic [8:0]    rdata;
    logic          penN;
    logic [8:0]    scanN;
  } pef_pins_t;

  typedef enum logic [3:0] {
    W_RESET, W_IDBURST, W_PREAMBLE, W_PREONES, W_DATA,
    W_POSTONES, W_POSTAMBLE, W_FILEMARK, W_DONE
  } pef_wstate_t;

endpackage

`default_nettype wire

// *** pef_formatter.sv ***
// Phase-encoded tape write sequencer and nine-channel read discriminator.
// Assumes the tape clocks and strobes are asynchronous pins sampled on core_clk,
// which must run well above twice the faster of the two tape clocks.
// Function
// - Last-byte pulse ends data, starts postamble
// - Data-input-low asserts, then toggles each tick
// - Flux clocks held one period: ones character
// - Postamble loads 80 reversals, 40 zeros
// - Upper high, lower low starts file mark
// - Cache write strobe idle during file mark
// - File mark: group b off while lower low
// - Count complete stops further flux reversals
// - Both lines high: preamble then data state
// - Diagnostic write keeps data-input-low inactive
// - Same discriminator logic on all nine channels
// - Dropout input registered onto drop flag
// - Read data delayed two edges, forward-corrected
// - First transition opens gate, enables window load
// - Window loads data value; 15 gives carry
// - Data-available sets, clears after scan strobe
// - Gap selects write bit clock as reference
// - Else channel 2, channel 1 when dropped
// - Up/down pulses from feedback lead or lag
// - Feedback divider: 22 clocks, preload 10
// - Six clocks, set flag, sixteen, reload, clear
// - Command codes on upper and lower lines
// - Write bit clock is doubled clock halved
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module pef_formatter (
  // Clock, reset, enable
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   clkEn,
  // Register port
  input  wire logic [3:0]             regAddr,
  input  wire logic [31:0]            regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic [31:0]                 regRdata,
  // Write side pins
  input  wire logic                   doubledWriteClock,
  input  wire pef_pkg::pef_cmdlines_t cmdLines,
  input  wire logic                   finalBytePulseN,
  input  wire logic [8:0]             cacheData,
  output logic                        cacheWriteStrobe,
  output logic                        dataInputLowN,
  output logic [8:0]                  fluxHead,
  output logic                        writeBitClock,
  // Read side pins
  input  wire logic                   recoveredReadClock,
  input  wire logic [8:0]             channelDropoutInN,
  input  wire logic [8:0]             digitizedReadPulse,
  input  wire logic                   phaseEnableQualifierN,
  input  wire logic [8:0]             channelScanStrobeN,
  output logic [8:0]                  channelDropFlag,
  output logic [8:0]                  channelBitValue,
  output logic [8:0]                  channelDataAvailable,
  output logic                        gapActive,
  output logic                        feedbackFlag,
  output logic                        phaseUp,
  output logic                        phaseDown
);
  import pef_pkg::*;

  function automatic logic [3:0] countOnes(input logic [8:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < CH_N; k++)
      n = n + {3'h0, v[k]};
    return n;
  endfunction

  pef_pins_t   pinsRaw;
  pef_pins_t   syncA_reg;
  pef_pins_t   pins_reg;
  logic        dwPrev_reg;
  logic        rrPrev_reg;
  logic        wTick;
  logic        rTick;
  pef_cmd_t    cmd;

  assign pinsRaw = '{dwClk: doubledWriteClock, cmd: cmdLines, finalN: finalBytePulseN,
                     rrClk: recoveredReadClock, dropN: channelDropoutInN,
                     rdata: digitizedReadPulse, penN: phaseEnableQualifierN,
                     scanN: channelScanStrobeN};

  // Two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_reg  <= '0;
      pins_reg   <= '0;
      dwPrev_reg <= 1'b0;
      rrPrev_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      syncA_reg  <= pinsRaw;
      pins_reg   <= syncA_reg;
      dwPrev_reg <= pins_reg.dwClk;
      rrPrev_reg <= pins_reg.rrClk;
    end
  end

  // Tape clock edges step the two halves
  assign wTick = clkEn & pins_reg.dwClk & ~dwPrev_reg;
  assign rTick = clkEn & pins_reg.rrClk & ~rrPrev_reg;
  assign cmd   = pef_cmd_t'(pins_reg.cmd);

  // Write sequencer state
  pef_wstate_t wState_reg, wState_next;
  logic [6:0]  fluxCnt_reg, fluxCnt_next;
  logic        frcTog_reg, frcTog_next;
  logic        write_bit_clock_reg, write_bit_clock_next;
  logic        dinLowN_reg, dinLowN_next;
  logic        postFirst_reg, postFirst_next;
  logic        strobe_reg, strobe_next;
  logic [8:0]  data_reg, data_next;
  logic [8:0]  head_reg, head_next;
  logic        frc;
  logic [8:0]  frcVec;
  logic        cntDone;
  logic        inPost;
  logic        finalByte;

  assign finalByte = ~pins_reg.finalN;
  assign cntDone   = (fluxCnt_reg == CNT_LAST);
  assign inPost    = (wState_reg == W_POSTONES) || (wState_reg == W_POSTAMBLE);

  // Flux clock source per state; held states give no reversals
  always_comb
  begin
    frc = 1'b0;
    if (wState_reg inside {W_IDBURST, W_PREAMBLE, W_POSTAMBLE, W_FILEMARK})
      frc = ~frcTog_reg;
    else if (wState_reg == W_DATA)
      frc = write_bit_clock_reg;
    frcVec = {CH_N{frc}};
    if (wState_reg == W_IDBURST)
      frcVec = frcVec & MASK_PARITY;
    else if (wState_reg == W_FILEMARK && !pins_reg.cmd.low)
      frcVec = frcVec & ~MASK_GROUP_B;
  end

  // Sequencer next state, advanced only on doubled write clock edges
  always_comb
  begin
    wState_next    = wState_reg;
    fluxCnt_next   = fluxCnt_reg;
    frcTog_next    = frcTog_reg;
    write_bit_clock_next    = write_bit_clock_reg;
    dinLowN_next   = dinLowN_reg;
    postFirst_next = postFirst_reg;
    strobe_next    = strobe_reg;
    data_next      = data_reg;
    head_next      = head_reg;
    if (wTick)
    begin
      frcTog_next  = ~frcTog_reg;
      write_bit_clock_next  = ~write_bit_clock_reg;
      fluxCnt_next = (fluxCnt_reg != 7'h00) ? fluxCnt_reg - CNT_LAST : fluxCnt_reg;
      unique case (wState_reg)
        W_RESET:
        begin
          fluxCnt_next = FLUX_COUNT;
          // Known flux phase, so the very first tick of a burst reverses
          frcTog_next  = 1'b0;
          if (cmd == CMD_IDBURST)
            wState_next = W_IDBURST;
          else if (cmd == CMD_FILEMARK)
            wState_next = W_FILEMARK;
          else if (cmd == CMD_WRITE)
            wState_next = W_PREAMBLE;
        end
        W_IDBURST: ;
        W_PREAMBLE:
          if (cntDone)
          begin
            wState_next  = W_PREONES;
            fluxCnt_next = ONES_TICKS;
          end
        W_PREONES:
          if (cntDone)
            wState_next = W_DATA;
        W_DATA:
          if (finalByte)
          begin
            wState_next    = W_POSTONES;
            fluxCnt_next   = ONES_TICKS;
            postFirst_next = 1'b1;
          end
        W_POSTONES:
          if (cntDone)
          begin
            wState_next  = W_POSTAMBLE;
            fluxCnt_next = FLUX_COUNT;
          end
        W_POSTAMBLE, W_FILEMARK:
          if (cntDone)
            wState_next = W_DONE;
        W_DONE: ;
      endcase
      // Lines back to reset abort whatever is running
      if (cmd == CMD_RESET)
        wState_next = W_RESET;
      // First tick of postamble drives low, then toggles
      if (inPost)
      begin
        dinLowN_next   = postFirst_reg ? 1'b0 : ~dinLowN_reg;
        postFirst_next = 1'b0;
      end
      else
        dinLowN_next = 1'b1;
      // Strobe runs only while fetching block data
      strobe_next = (wState_reg == W_DATA) && !finalByte && !write_bit_clock_reg;
      if (!dinLowN_reg)
        data_next = 9'h000;
      else if (strobe_reg)
        data_next = cacheData;
      // Reset and finished states hold the heads still
      if (wState_reg != W_RESET && wState_reg != W_DONE)
        head_next = ((dinLowN_reg && !inPost) ? data_reg : 9'h000) ^ frcVec;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wState_reg    <= W_RESET;
      fluxCnt_reg   <= 7'h00;
      frcTog_reg    <= 1'b0;
      write_bit_clock_reg    <= 1'b0;
      dinLowN_reg   <= 1'b1;
      postFirst_reg <= 1'b0;
      strobe_reg    <= 1'b0;
      data_reg      <= 9'h000;
      head_reg      <= 9'h000;
    end
    else if (clkEn)
    begin
      wState_reg    <= wState_next;
      fluxCnt_reg   <= fluxCnt_next;
      frcTog_reg    <= frcTog_next;
      write_bit_clock_reg    <= write_bit_clock_next;
      dinLowN_reg   <= dinLowN_next;
      postFirst_reg <= postFirst_next;
      strobe_reg    <= strobe_next;
      data_reg      <= data_next;
      head_reg      <= head_next;
    end
  end

  assign cacheWriteStrobe = strobe_reg;
  assign dataInputLowN    = dinLowN_reg;
  assign fluxHead         = head_reg;
  assign writeBitClock    = write_bit_clock_reg;

  // Read discriminators and clock recovery
  logic [31:0] ctrl_reg, ctrl_next;
  logic [8:0]  drop_reg, drop_next;
  logic [8:0]  rd1_reg, rd1_next;
  logic [8:0]  bv_reg, bv_next;
  logic [8:0]  armed_reg, armed_next;
  logic [8:0]  dav_reg, dav_next;
  logic [3:0]  win_reg [CH_N];
  logic [3:0]  win_next [CH_N];
  logic [8:0]  acc;
  logic        forward_direction;
  logic        gap_reg, gap_next;
  logic        refPulse;
  logic        fbPulse;
  logic [3:0]  div_reg, div_next;
  logic        flag_reg, flag_next;
  logic        clrPend_reg, clrPend_next;
  logic        refSeen_reg, refSeen_next;
  logic        fbSeen_reg, fbSeen_next;
  logic        up_reg, up_next;
  logic        down_reg, down_next;
  logic        divCarry;

  assign forward_direction      = ctrl_reg[CTRL_FWD_BIT];
  assign divCarry = (div_reg == DIV_TOP);
  assign fbPulse  = rTick & divCarry & ~flag_reg & ~clrPend_reg;

  // Reference pick: bit clock in a gap, else channel 2 or its fallback
  assign refPulse = gap_reg ? (wTick & ~write_bit_clock_reg)
                  : (drop_reg[2] ? acc[1] : acc[2]);

  // Per-channel discriminator, identical for every channel
  always_comb
  begin
    for (int i = 0; i < CH_N; i++)
    begin
      logic trans;
      logic fresh;
      trans = 1'b0;
      fresh = rd1_reg[i] ^ forward_direction;
      trans = rTick & (fresh ^ bv_reg[i]);
      acc[i]      = trans & (~armed_reg[i] | (win_reg[i] == WIN_FULL));
      drop_next[i] = rTick ? ~pins_reg.dropN[i] : drop_reg[i];
      rd1_next[i]  = rTick ? pins_reg.rdata[i] : rd1_reg[i];
      bv_next[i]   = rTick ? fresh : bv_reg[i];
      // Gate stays shut until the first transition, unless qualified
      armed_next[i] = drop_reg[i] ? 1'b0
                    : ((trans | ~pins_reg.penN) ? 1'b1 : armed_reg[i]);
      if (acc[i])
        win_next[i] = {4{fresh}};
      else if (rTick && win_reg[i] != WIN_FULL)
        win_next[i] = win_reg[i] + WIN_STEP;
      else
        win_next[i] = win_reg[i];
      // Scan strobe sampled active wins; a set never lands during scan
      if (rTick && !pins_reg.scanN[i])
        dav_next[i] = 1'b0;
      else if (acc[i])
        dav_next[i] = 1'b1;
      else
        dav_next[i] = dav_reg[i];
    end
  end

  // Divide-by-22 feedback and lead/lag detector
  always_comb
  begin
    gap_next     = rTick ? (countOnes(drop_reg) >= GAP_MIN) : gap_reg;
    div_next     = div_reg;
    flag_next    = flag_reg;
    clrPend_next = clrPend_reg;
    if (rTick)
    begin
      div_next     = (divCarry && flag_reg) ? DIV_PRELOAD : div_reg + WIN_STEP;
      clrPend_next = divCarry & flag_reg;
      if (clrPend_reg)
        flag_next = 1'b0;
      else if (divCarry && !flag_reg)
        flag_next = 1'b1;
    end
    up_next      = 1'b0;
    down_next    = 1'b0;
    refSeen_next = refSeen_reg;
    fbSeen_next  = fbSeen_reg;
    if (refPulse && fbPulse)
    begin
      refSeen_next = 1'b0;
      fbSeen_next  = 1'b0;
    end
    else if (refPulse)
    begin
      down_next    = fbSeen_reg;
      fbSeen_next  = 1'b0;
      refSeen_next = ~fbSeen_reg;
    end
    else if (fbPulse)
    begin
      up_next      = refSeen_reg;
      refSeen_next = 1'b0;
      fbSeen_next  = ~refSeen_reg;
    end
    ctrl_next = (regWr && regAddr == REG_CTRL) ? regWdata : ctrl_reg;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drop_reg    <= 9'h000;
      rd1_reg     <= 9'h000;
      bv_reg      <= 9'h000;
      armed_reg   <= 9'h000;
      dav_reg     <= 9'h000;
      win_reg     <= '{default: 4'h0};
      gap_reg     <= 1'b0;
      div_reg     <= DIV_PRELOAD;
      flag_reg    <= 1'b0;
      clrPend_reg <= 1'b0;
      refSeen_reg <= 1'b0;
      fbSeen_reg  <= 1'b0;
      up_reg      <= 1'b0;
      down_reg    <= 1'b0;
      ctrl_reg    <= CTRL_RESET;
    end
    else if (clkEn)
    begin
      drop_reg    <= drop_next;
      rd1_reg     <= rd1_next;
      bv_reg      <= bv_next;
      armed_reg   <= armed_next;
      dav_reg     <= dav_next;
      win_reg     <= win_next;
      gap_reg     <= gap_next;
      div_reg     <= div_next;
      flag_reg    <= flag_next;
      clrPend_reg <= clrPend_next;
      refSeen_reg <= refSeen_next;
      fbSeen_reg  <= fbSeen_next;
      up_reg      <= up_next;
      down_reg    <= down_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  // Read data valid only in the cycle after the strobe
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] status;
  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_DROP_LSB +: CH_N] = drop_reg;
    status[ST_GAP_BIT]          = gap_reg;
    status[ST_DAV_LSB +: CH_N]  = dav_reg;
    status[ST_STATE_LSB +: 4]   = wState_reg;
    rdata_next = 32'h0000_0000;
    if (regRd && regAddr == REG_CTRL)
      rdata_next = ctrl_reg;
    else if (regRd && regAddr == REG_STATUS)
      rdata_next = status;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= 32'h0000_0000;
    else if (clkEn)
      rdata_reg <= rdata_next;
  end

  assign regRdata             = rdata_reg;
  assign channelDropFlag      = drop_reg;
  assign channelBitValue      = bv_reg;
  assign channelDataAvailable = dav_reg;
  assign gapActive            = gap_reg;
  assign feedbackFlag         = flag_reg;
  assign phaseUp              = up_reg;
  assign phaseDown            = down_reg;

  // Checks on the logic above
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n || !clkEn);

  sequence s_last_byte;
    wTick && wState_reg == W_DATA && finalByte && cmd != CMD_RESET;
  endsequence
  sequence s_post_step;
    wTick && inPost;
  endsequence

  a_post_entry: assert property (s_last_byte |=> wState_reg == W_POSTONES)
    else $error("postamble not entered on last byte");
  a_data_input_low_ctl_toggle: assert property (s_post_step |=> dinLowN_reg != $past(dinLowN_reg))
    else $error("data-input-low not toggling in postamble");
  a_ones_heads: assert property (wTick && wState_reg == W_POSTONES |=> head_reg == 9'h000)
    else $error("ones character not written");
  a_post_load: assert property
    (wTick && wState_reg == W_POSTONES && cntDone && cmd != CMD_RESET
     |=> fluxCnt_reg == FLUX_COUNT)
    else $error("postamble count not loaded");
  a_fm_start: assert property
    (wTick && wState_reg == W_RESET && cmd == CMD_FILEMARK |=> wState_reg == W_FILEMARK)
    else $error("file mark not started");
  a_fm_strobe: assert property (wState_reg == W_FILEMARK |-> !strobe_reg)
    else $error("cache strobe active in file mark");
  a_fm_group: assert property
    (wTick && wState_reg == W_FILEMARK && !pins_reg.cmd.low
     |=> (head_reg & MASK_GROUP_B) == 9'h000)
    else $error("group b written in file mark");
  a_done_still: assert property (wState_reg == W_DONE ##1 wState_reg == W_DONE
    |-> $stable(head_reg))
    else $error("reversal after count complete");
  a_reset_quiet: assert property (wState_reg == W_RESET |=> $stable(head_reg) && !strobe_reg)
    else $error("activity in reset state");
  a_drop_copy: assert property (rTick |=> drop_reg == ~$past(pins_reg.dropN))
    else $error("drop flag not registered");
  a_dav_clear: assert property (rTick && !pins_reg.scanN[2] |=> !dav_reg[2])
    else $error("data-available not cleared by scan");
  a_gap_ref: assert property (gap_reg |-> refPulse == (wTick && !write_bit_clock_reg))
    else $error("gap reference not bit clock");
  a_div_reload: assert property (rTick && divCarry && flag_reg
    |=> div_reg == DIV_PRELOAD ##1 (!flag_reg || !rTick)[*1])
    else $error("divider not reloaded");

endmodule

`default_nettype wire

// *** pef_tape_model.sv ***
// Tape-side model: doubled write clock, recovered read clock, read channels.
// Assumes the bench chooses read-after-write loopback or its own read pattern.
`timescale 1ns/10ps
`default_nettype none

module pef_tape_model (
  // Clocks toward the formatter
  output logic            dwClk,
  output logic            rrClk,
  // Head drive and read channels
  input  wire logic [8:0] fluxHead,
  input  wire logic       loopBack,
  input  wire logic [8:0] tbData,
  output logic [8:0]      readPulse
);
  // Whole multiples of 50 ns, so counts seen on core_clk repeat exactly
  initial
  begin
    dwClk = 1'b0;
    rrClk = 1'b0;
  end
  always #200 dwClk = ~dwClk;
  always #300 rrClk = ~rrClk;

  // Read head sees what was written, or the bench's own pattern
  assign readPulse = loopBack ? fluxHead : tbData;
endmodule

`default_nettype wire

// *** pef_formatter_tb.sv ***
// Self-checking bench: registers, read discriminators, file mark, block write.
// Assumes the tape model supplies both tape clocks; core clock is 20 MHz.
`timescale 1ns/10ps
`default_nettype none

module pef_formatter_tb;
  import pef_pkg::*;
  typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d; logic [31:0] e;} pef_row_t;

  logic          core_clk = 1'b0;
  logic          arst_n   = 1'b0;
  logic [3:0]    regAddr  = 4'h0;
  logic [31:0]   regWdata = 32'h0;
  logic          regWr    = 1'b0;
  logic          regRd    = 1'b0;
  pef_cmdlines_t cmdLines = '0;
  logic          finalN   = 1'b1;
  logic          penN     = 1'b1;
  logic [8:0]    dropN    = 9'h1FF;
  logic [8:0]    scanN    = 9'h1FF;
  logic [8:0]    tbData   = 9'h000;
  logic          loopBack = 1'b0;
  logic          clkEn    = 1'b1;
  logic          phUp, phDn;
  logic          dwClk, rrClk, strobe, dinLowN, write_bit_clock, gap, fbFlag;
  logic [8:0]    flux, rdPulse, drop, bitVal, dav;
  logic [31:0]   regRdata, q;
  logic [9:0]    acc;
  int            nFail, cmpCount, cycles, n, t0, nUp, nDn;
  // Ordinary register cases; unmapped 0x8 and read-only status take no write
  pef_row_t      rows [0:6] = '{
    '{1'b0, REG_CTRL, 32'h0, CTRL_RESET}, '{1'b1, REG_CTRL, 32'hA5A5_5A5A, 32'h0},
    '{1'b0, REG_CTRL, 32'h0, 32'hA5A5_5A5A}, '{1'b1, REG_STATUS, 32'hFFFF_FFFF, 32'h0},
    '{1'b1, 4'h8, 32'hFFFF_FFFF, 32'h0}, '{1'b0, REG_STATUS, 32'h0, 32'h0},
    '{1'b0, 4'h8, 32'h0, 32'h0}};

  pef_tape_model pef_tape_model_i (.dwClk(dwClk), .rrClk(rrClk), .fluxHead(flux),
    .loopBack(loopBack), .tbData(tbData), .readPulse(rdPulse));

  pef_formatter pef_formatter_i (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .doubledWriteClock(dwClk), .cmdLines(cmdLines),
    .finalBytePulseN(finalN), .cacheData(9'h0A5), .cacheWriteStrobe(strobe),
    .dataInputLowN(dinLowN), .fluxHead(flux), .writeBitClock(write_bit_clock),
    .recoveredReadClock(rrClk), .channelDropoutInN(dropN), .digitizedReadPulse(rdPulse),
    .phaseEnableQualifierN(penN), .channelScanStrobeN(scanN), .channelDropFlag(drop),
    .channelBitValue(bitVal), .channelDataAvailable(dav), .gapActive(gap),
    .feedbackFlag(fbFlag), .phaseUp(phUp), .phaseDown(phDn));

  always #25 core_clk = ~core_clk;

  // Hang guard: the whole run needs about 5000 cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (phUp === 1'b1)
      nUp <= nUp + 1;
    if (phDn === 1'b1)
      nDn <= nDn + 1;
    if (cycles == 12000)
    begin
      nFail = nFail + 1;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      nFail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One strobe cycle; read data is taken at the edge after it
  task automatic regAcc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= wr;
    regRd <= !wr;
    @(posedge core_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(posedge core_clk);
    q = regRdata;
  endtask

  // Polls status until the write state matches, bounded
  task automatic waitState(input logic [3:0] s);
    n = 0;
    do
    begin
      regAcc(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[ST_STATE_LSB +: 4] !== s && n < 1000);
    chk({28'h0, q[ST_STATE_LSB +: 4]}, {28'h0, s});
  endtask

  // Counts channel 0 reversals; collects group b bits and the strobe
  task automatic watch(input int len);
    n = 0;
    acc = 10'h000;
    for (int k = 0; k < len; k++)
    begin
      @(posedge core_clk);
      if (k > 0 && flux[0] !== t0[0])
        n++;
      t0[0] = flux[0];
      acc = acc | {strobe, flux & MASK_GROUP_B};
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    chk({20'h0, strobe, dinLowN, write_bit_clock, flux}, 32'h400);
    chk({fbFlag, gap, dav, bitVal, drop}, 32'h0);
    @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    $display("done: reset");
    foreach (rows[i])
    begin
      regAcc(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr)
        chk(q, rows[i].e);
    end
    regAcc(1'b1, REG_CTRL, CTRL_RESET);
    $display("done: registers");
    // Read side: polarity, dropout, gap, divider, data-available
    repeat (100) @(posedge core_clk);
    chk({23'h0, bitVal}, 32'h1FF);
    regAcc(1'b1, REG_CTRL, 32'h0);
    repeat (100) @(posedge core_clk);
    chk({23'h0, bitVal}, 32'h0);
    tbData <= 9'h1FF;
    repeat (100) @(posedge core_clk);
    chk({23'h0, bitVal}, 32'h1FF);
    dropN <= ~9'h004;
    repeat (100) @(posedge core_clk);
    chk({22'h0, gap, drop}, 32'h004);
    dropN <= ~9'h006;
    repeat (100) @(posedge core_clk);
    chk({22'h0, gap, drop}, 32'h206);
    // Gap reference is far faster than feedback: only up pulses
    t0 = nUp;
    n = nDn;
    repeat (300) @(posedge core_clk);
    chk({31'h0, nUp != t0}, 32'h1);
    chk(32'(nDn - n), 32'h0);
    dropN <= 9'h1FF;
    for (int k = 0; k < 600 && fbFlag !== 1'b0; k++) @(posedge core_clk);
    for (int k = 0; k < 600 && fbFlag !== 1'b1; k++) @(posedge core_clk);
    t0 = cycles;
    for (int k = 0; k < 600 && fbFlag !== 1'b0; k++) @(posedge core_clk);
    for (int k = 0; k < 600 && fbFlag !== 1'b1; k++) @(posedge core_clk);
    chk(32'(cycles - t0), 32'h108);
    // Earlier polarity flips set every flag; scan them clear first
    scanN <= 9'h000;
    repeat (60) @(posedge core_clk);
    scanN <= 9'h1FF;
    chk({23'h0, dav}, 32'h0);
    penN <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      tbData[0] <= ~tbData[0];
      repeat (240) @(posedge core_clk);
    end
    chk({23'h0, dav}, 32'h001);
    scanN <= 9'h000;
    repeat (60) @(posedge core_clk);
    chk({23'h0, dav}, 32'h0);
    scanN <= 9'h1FF;
    $display("done: read side");
    // File mark: 80 reversals on its channels, group b and strobe idle
    cmdLines <= '{high: 1'b1, low: 1'b0};
    watch(1000);
    chk(32'(n), 32'h50);
    chk({22'h0, acc}, 32'h0);
    waitState(4'h8);
    cmdLines <= '{high: 1'b0, low: 1'b0};
    waitState(4'h0);
    watch(100);
    chk({n[21:0], acc}, 32'h0);
    // Identification burst: parity only, no strobe
    cmdLines <= '{high: 1'b0, low: 1'b1};
    waitState(4'h1);
    watch(100);
    chk({n[21:0], acc}, 32'h0);
    cmdLines <= '{high: 1'b0, low: 1'b0};
    waitState(4'h0);
    $display("done: file mark");
    // Block write, ended by the last-byte pulse
    loopBack <= 1'b1;
    cmdLines <= '{high: 1'b1, low: 1'b1};
    waitState(4'h4);
    chk({31'h0, dinLowN}, 32'h1);
    // Clock enable low must freeze the bit clock divider
    clkEn <= 1'b0;
    @(posedge core_clk);
    t0 = write_bit_clock;
    repeat (40) @(posedge core_clk);
    chk({31'h0, write_bit_clock}, 32'(t0));
    clkEn <= 1'b1;
    finalN <= 1'b0;
    repeat (20) @(posedge core_clk);
    finalN <= 1'b1;
    for (int k = 0; k < 60 && dinLowN !== 1'b0; k++) @(posedge core_clk);
    chk({31'h0, dinLowN}, 32'h0);
    for (int k = 0; k < 12 && dinLowN !== 1'b1; k++) @(posedge core_clk);
    chk({31'h0, dinLowN}, 32'h1);
    waitState(4'h8);
    cmdLines <= '{high: 1'b0, low: 1'b0};
    waitState(4'h0);
    $display("done: block write");
    final_report();
  end
endmodule

`default_nettype wire
